//--- dbg_uart_params.svh
`ifndef DBG_UART_PARAMS_SVH
`define DBG_UART_PARAMS_SVH

// Register byte offsets
`define DBG_ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_MODE 8'h04
`define OFF_IRQ_SET 8'h08
`define OFF_IRQ_CLR 8'h0C
`define OFF_IRQ_VIEW 8'h10
`define OFF_STATUS 8'h14
`define OFF_RX_HOLD 8'h18
`define OFF_TX_HOLD 8'h1C
`define OFF_BAUD 8'h20

// Shared interrupt and status bit layout
`define BIT_RX_READY 0
`define BIT_TX_READY 1
`define BIT_RX_DMA_DONE 3
`define BIT_TX_DMA_DONE 4
`define BIT_OVERRUN 5
`define BIT_FRAMING 6
`define BIT_PARITY 7
`define BIT_TX_IDLE 9
`define BIT_TX_BUF_EMPTY 11
`define BIT_RX_BUF_FULL 12
`define BIT_DBG_WR 30
`define BIT_DBG_RD 31
`define IRQ_DEFINED 32'hC000_1AFB

// Control register command bits
`define CR_RX_RESET 2
`define CR_TX_RESET 3
`define CR_RX_ON 4
`define CR_RX_OFF 5
`define CR_TX_ON 6
`define CR_TX_OFF 7
`define CR_ERR_CLR 8

// Mode register fields
`define MR_MODE_LO 14
`define MR_PAR_LO 9
`define MR_PAR_RESET 3'h0

// Baud generator
`define DIV_W 16
`define BAUD_CNT_W 20
`define DIV_OFF 16'h0000
`define DIV_PASS 16'h0001
`define RESET_WORD 32'h0000_0000

`endif

//--- dbg_uart_pkg.sv
`default_nettype none
package dbg_uart_pkg;

    typedef enum logic [2:0] {
        TX_OFF = 3'b001,
        TX_EMPTY = 3'b010,
        TX_FULL = 3'b100
    } tx_state_e;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_ECHO = 2'b01,
        MODE_LOCAL = 2'b10,
        MODE_REMOTE = 2'b11
    } chan_mode_e;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic frame_err;
        logic parity_err;
    } rx_event_s;

    typedef struct packed {
        logic rx_done;
        logic tx_done;
        logic tx_buf_empty;
        logic rx_buf_full;
    } dma_status_s;

endpackage
`default_nettype wire

//--- baud_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_uart_params.svh"

module baud_tick_gen (
    input wire logic clk, // Master clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [`DIV_W-1:0] divisor, // Divisor value
    output logic baud_tick // Baud clock pulse
);
    logic [`BAUD_CNT_W-1:0] cnt_q;
    logic [`BAUD_CNT_W-1:0] cnt_d;
    logic [`BAUD_CNT_W-1:0] last;
    logic tick_q;
    logic tick_d;
    logic dividing;

    assign last = {divisor, 4'h0} - 20'h0_0001;
    assign dividing = divisor > `DIV_PASS;
    assign cnt_d = (!dividing || cnt_q >= last) ? 20'h0_0000 : cnt_q + 20'h0_0001;
    assign tick_d = (divisor == `DIV_PASS) | (dividing & (cnt_q == last));
    assign baud_tick = tick_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 20'h0_0000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_BAUD_OFF: assert property (
        (divisor == `DIV_OFF) && $past(divisor == `DIV_OFF) |-> !baud_tick)
        else $error("baud tick while divisor is zero");
    AST_BAUD_PASS: assert property (
        (divisor == `DIV_PASS) && $past(divisor == `DIV_PASS) |-> baud_tick)
        else $error("baud tick missing with divisor one");
    AST_BAUD_DIV: assert property (
        baud_tick && dividing ##1 (dividing && $stable(divisor)) [*2] |-> !baud_tick)
        else $error("divided baud tick too early");
endmodule
`default_nettype wire

//--- debug_uart_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_uart_params.svh"

module debug_uart_regs (
    input wire logic clk, // Master clock, 125 MHz
    input wire logic rst_n, // Synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [`DBG_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire dbg_uart_pkg::rx_event_s rx_in, // Character from receive shifter
    input wire logic tx_shift_ready, // Transmit shifter can take a character
    input wire logic tx_shifting, // Transmit shifter busy
    input wire logic tx_shift_bit, // Transmit shifter serial output
    output logic tx_load, // Character handed to shifter
    output logic [7:0] char_to_send, // Character for the shifter
    output logic rx_shift_bit, // Serial input to receive shifter
    input wire logic serial_in_pin, // Serial line in
    output logic serial_out_pin, // Serial line out
    input wire dbg_uart_pkg::dma_status_s dma_in, // DMA channel status
    input wire logic debug_channel_read_pending, // Debug channel read flag
    input wire logic debug_channel_write_pending, // Debug channel write flag
    output logic rx_enable, // Receiver enabled
    output logic tx_enable, // Transmitter active
    output logic [2:0] parity_mode, // Parity selection
    output logic baud_tick, // Baud clock pulse
    output logic rx_dma_request, // Receive DMA trigger
    output logic tx_dma_request, // Transmit DMA trigger
    output logic irq // Interrupt request
);
    function automatic logic hit(input logic [`DBG_ADDR_W-1:0] a,
        input logic [`DBG_ADDR_W-1:0] off);
        return a == off;
    endfunction

    logic setup;
    logic access;
    logic wr;
    logic sel_ctrl;
    logic sel_mode;
    logic sel_iset;
    logic sel_iclr;
    logic sel_iview;
    logic sel_stat;
    logic sel_rhr;
    logic sel_thr;
    logic sel_baud;
    logic mapped;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_iset;
    logic wr_iclr;
    logic wr_thr;
    logic wr_baud;
    logic rhr_read;
    logic [31:0] rd_mux;
    logic [31:0] mode_view;
    logic [31:0] prdata_q;
    logic err_q;

    logic [31:0] irq_mask_q;
    logic [31:0] irq_mask_d;
    logic [31:0] line_status;
    logic irq_q;
    dbg_uart_pkg::chan_mode_e mode_q;
    logic [2:0] par_q;
    logic [`DIV_W-1:0] divisor_value_q;

    logic rx_en_q;
    logic rx_en_d;
    logic rx_load;
    logic rx_late_q;
    logic rx_clear;
    logic receive_ready_q;
    logic receive_ready_d;
    logic [7:0] received_char_q;
    logic [2:0] err_flags_q;
    logic [2:0] err_set;
    logic err_clr;

    logic tx_en_q;
    logic tx_en_d;
    dbg_uart_pkg::tx_state_e tx_state_q;
    dbg_uart_pkg::tx_state_e tx_state_d;
    logic [7:0] char_to_send_q;
    logic serial_out_q;
    logic serial_out_d;
    logic rx_bit_q;
    logic rx_bit_d;

    // Bus decode
    assign setup = psel & !penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign sel_ctrl = hit(paddr, `OFF_CTRL);
    assign sel_mode = hit(paddr, `OFF_MODE);
    assign sel_iset = hit(paddr, `OFF_IRQ_SET);
    assign sel_iclr = hit(paddr, `OFF_IRQ_CLR);
    assign sel_iview = hit(paddr, `OFF_IRQ_VIEW);
    assign sel_stat = hit(paddr, `OFF_STATUS);
    assign sel_rhr = hit(paddr, `OFF_RX_HOLD);
    assign sel_thr = hit(paddr, `OFF_TX_HOLD);
    assign sel_baud = hit(paddr, `OFF_BAUD);
    assign mapped = sel_ctrl | sel_mode | sel_iset | sel_iclr | sel_iview | sel_stat
        | sel_rhr | sel_thr | sel_baud;
    assign wr_ctrl = wr & sel_ctrl;
    assign wr_mode = wr & sel_mode;
    assign wr_iset = wr & sel_iset;
    assign wr_iclr = wr & sel_iclr;
    assign wr_thr = wr & sel_thr;
    assign wr_baud = wr & sel_baud;
    assign rhr_read = access & !pwrite & sel_rhr;

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = access & err_q;

    assign mode_view = ({30'h0, mode_q} << `MR_MODE_LO)
        | ({29'h0, par_q} << `MR_PAR_LO);
    assign rd_mux = sel_mode ? mode_view
        : sel_iview ? irq_mask_q
        : sel_stat ? line_status
        : sel_rhr ? {24'h00_0000, received_char_q}
        : sel_baud ? {16'h0000, divisor_value_q}
        : `RESET_WORD;

    assign irq_mask_d = (irq_mask_q | ({32{wr_iset}} & pwdata & `IRQ_DEFINED))
        & ~({32{wr_iclr}} & pwdata);

    always_comb
    begin
        line_status = `RESET_WORD;
        line_status[`BIT_RX_READY] = receive_ready_q;
        line_status[`BIT_TX_READY] = tx_state_q == dbg_uart_pkg::TX_EMPTY;
        line_status[`BIT_RX_DMA_DONE] = dma_in.rx_done;
        line_status[`BIT_TX_DMA_DONE] = dma_in.tx_done;
        line_status[`BIT_OVERRUN] = err_flags_q[0];
        line_status[`BIT_FRAMING] = err_flags_q[1];
        line_status[`BIT_PARITY] = err_flags_q[2];
        line_status[`BIT_TX_IDLE] = (tx_state_q == dbg_uart_pkg::TX_EMPTY) & !tx_shifting;
        line_status[`BIT_TX_BUF_EMPTY] = dma_in.tx_buf_empty;
        line_status[`BIT_RX_BUF_FULL] = dma_in.rx_buf_full;
        line_status[`BIT_DBG_WR] = debug_channel_write_pending;
        line_status[`BIT_DBG_RD] = debug_channel_read_pending;
    end

    // Receive path
    assign rx_en_d = (wr_ctrl & (pwdata[`CR_RX_RESET] | pwdata[`CR_RX_OFF])) ? 1'b0
        : (wr_ctrl & pwdata[`CR_RX_ON]) ? 1'b1 : rx_en_q;
    assign rx_load = rx_in.valid & rx_en_q & (mode_q != dbg_uart_pkg::MODE_REMOTE);
    assign rx_clear = rhr_read & !rx_late_q;
    assign receive_ready_d = rx_en_d & (rx_load | (receive_ready_q & !rx_clear));
    assign err_set = {rx_load & rx_in.parity_err, rx_load & rx_in.frame_err,
        rx_load & receive_ready_q & !rx_clear};
    assign err_clr = wr_ctrl & pwdata[`CR_ERR_CLR];

    // Transmit path
    assign tx_en_d = (wr_ctrl & (pwdata[`CR_TX_RESET] | pwdata[`CR_TX_OFF])) ? 1'b0
        : (wr_ctrl & pwdata[`CR_TX_ON]) ? 1'b1 : tx_en_q;
    assign tx_load = (tx_state_q == dbg_uart_pkg::TX_FULL) & tx_shift_ready
        & (mode_q != dbg_uart_pkg::MODE_REMOTE);

    always_comb
    begin
        tx_state_d = tx_state_q;
        unique case (tx_state_q)
            dbg_uart_pkg::TX_OFF:
            begin
                if (tx_en_d)
                    tx_state_d = dbg_uart_pkg::TX_EMPTY;
            end
            dbg_uart_pkg::TX_EMPTY:
            begin
                if (!tx_en_d)
                    tx_state_d = dbg_uart_pkg::TX_OFF;
                else if (wr_thr)
                    tx_state_d = dbg_uart_pkg::TX_FULL;
            end
            dbg_uart_pkg::TX_FULL:
            begin
                if (wr_ctrl & pwdata[`CR_TX_RESET])
                    tx_state_d = dbg_uart_pkg::TX_OFF;
                else if (tx_load)
                    tx_state_d = tx_en_d ? dbg_uart_pkg::TX_EMPTY : dbg_uart_pkg::TX_OFF;
            end
            default:
                tx_state_d = dbg_uart_pkg::TX_OFF;
        endcase
    end

    assign serial_out_d = (mode_q == dbg_uart_pkg::MODE_LOCAL) ? 1'b1
        : (mode_q == dbg_uart_pkg::MODE_NORMAL) ? tx_shift_bit : serial_in_pin;
    assign rx_bit_d = (mode_q == dbg_uart_pkg::MODE_LOCAL) ? tx_shift_bit
        : (mode_q == dbg_uart_pkg::MODE_REMOTE) ? 1'b1 : serial_in_pin;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata_q <= `RESET_WORD;
            err_q <= 1'b0;
            irq_mask_q <= `RESET_WORD;
            irq_q <= 1'b0;
            mode_q <= dbg_uart_pkg::MODE_NORMAL;
            par_q <= `MR_PAR_RESET;
            divisor_value_q <= `DIV_OFF;
            rx_en_q <= 1'b0;
            rx_late_q <= 1'b0;
            receive_ready_q <= 1'b0;
            received_char_q <= 8'h00;
            err_flags_q <= 3'h0;
            tx_en_q <= 1'b0;
            tx_state_q <= dbg_uart_pkg::TX_OFF;
            char_to_send_q <= 8'h00;
            serial_out_q <= 1'b1;
            rx_bit_q <= 1'b1;
        end
        else
        begin
            if (setup)
            begin
                prdata_q <= rd_mux;
                err_q <= !mapped;
            end
            rx_late_q <= setup & rx_load;
            irq_mask_q <= irq_mask_d;
            irq_q <= |(line_status & irq_mask_q);
            if (wr_mode)
            begin
                mode_q <= dbg_uart_pkg::chan_mode_e'(pwdata[`MR_MODE_LO +: 2]);
                par_q <= pwdata[`MR_PAR_LO +: 3];
            end
            if (wr_baud)
                divisor_value_q <= pwdata[`DIV_W-1:0];
            rx_en_q <= rx_en_d;
            receive_ready_q <= receive_ready_d;
            if (rx_load)
                received_char_q <= rx_in.data;
            err_flags_q <= err_set | (err_flags_q & ~{3{err_clr}});
            tx_en_q <= tx_en_d;
            tx_state_q <= tx_state_d;
            if (wr_thr && tx_state_q != dbg_uart_pkg::TX_OFF)
                char_to_send_q <= pwdata[7:0];
            serial_out_q <= serial_out_d;
            rx_bit_q <= rx_bit_d;
        end
    end

    baud_tick_gen baud_tick_gen_inst (
        .clk(clk),
        .rst_n(rst_n),
        .divisor(divisor_value_q),
        .baud_tick(baud_tick)
    );

    assign char_to_send = char_to_send_q;
    assign rx_shift_bit = rx_bit_q;
    assign serial_out_pin = serial_out_q;
    assign rx_enable = rx_en_q;
    assign tx_enable = tx_state_q != dbg_uart_pkg::TX_OFF;
    assign parity_mode = par_q;
    assign rx_dma_request = receive_ready_q;
    assign tx_dma_request = line_status[`BIT_TX_READY];
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_thr_write;
        wr_thr && tx_state_q == dbg_uart_pkg::TX_EMPTY && tx_en_d;
    endsequence
    sequence s_err_clear;
        err_clr && !rx_load;
    endsequence

    AST_IER_SETS: assert property (
        wr_iset |=> ((irq_mask_q & $past(pwdata)) == ($past(pwdata) & `IRQ_DEFINED)))
        else $error("enable-set write did not set mask");
    AST_IDR_CLEARS: assert property (
        wr_iclr |=> ((irq_mask_q & $past(pwdata)) == `RESET_WORD))
        else $error("enable-clear write did not clear mask");
    AST_IMR_READ: assert property (
        setup && !pwrite && sel_iview |=> prdata == $past(irq_mask_q))
        else $error("mask view read wrong");
    AST_RX_READY_SET: assert property (
        rx_load && rx_en_d |=> line_status[`BIT_RX_READY] && received_char_q == $past(rx_in.data))
        else $error("receive ready not set on character");
    AST_RX_READY_OFF: assert property (
        !rx_en_q |-> !line_status[`BIT_RX_READY])
        else $error("receive ready while receiver disabled");
    AST_TX_PENDING: assert property (
        s_thr_write |=> !line_status[`BIT_TX_READY] && !line_status[`BIT_TX_IDLE])
        else $error("transmit ready after character written");
    AST_TX_HANDOFF: assert property (
        tx_load && tx_en_d && !(wr_ctrl && pwdata[`CR_TX_RESET]) |=> line_status[`BIT_TX_READY])
        else $error("transmit ready missing after handoff");
    AST_ERR_STICKY: assert property (
        err_flags_q[0] && !err_clr |=> err_flags_q[0])
        else $error("overrun flag dropped without clear");
    AST_ERR_CLEAR: assert property (
        s_err_clear |=> err_flags_q == 3'h0)
        else $error("error flags not cleared");
    AST_IRQ: assert property (
        |(line_status & irq_mask_q) ##1 $stable(irq_mask_q) |-> irq)
        else $error("interrupt missing for masked status");
    AST_ECHO: assert property (
        mode_q == dbg_uart_pkg::MODE_ECHO |=> serial_out_pin == $past(serial_in_pin))
        else $error("echo mode pin routing wrong");
    AST_MIRROR: assert property (
        ##1 line_status[`BIT_DBG_RD] == debug_channel_read_pending)
        else $error("debug read flag not mirrored");
endmodule
`default_nettype wire

//--- host_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    input wire logic clk, // Master clock
    input wire logic rst_n, // Synchronous reset
    input wire logic tx_load, // Character offered
    input wire logic [7:0] char_to_send, // Offered character
    output var dbg_uart_pkg::rx_event_s rx_in, // Received character pulse
    output logic tx_shift_ready, // Shifter free
    output logic tx_shifting, // Shifter busy
    output logic tx_shift_bit, // Shifter serial bit
    output logic serial_in_pin // Line towards the unit
);
    logic stall_q = 1'b0;
    logic line_q = 1'b1;
    logic bit_q = 1'b1;
    logic [2:0] busy_q = 3'h0;
    logic [7:0] sent_q = 8'h00;
    int nsent = 0;
    initial rx_in = '0;
    assign tx_shifting = busy_q != 3'h0;
    assign tx_shift_ready = !stall_q && !tx_shifting;
    assign tx_shift_bit = bit_q;
    assign serial_in_pin = line_q;
    always @(posedge clk)
    begin
        if (!rst_n)
            busy_q <= 3'h0;
        else if (tx_load)
        begin
            sent_q <= char_to_send;
            nsent <= nsent + 1;
            busy_q <= 3'h4;
        end
        else if (tx_shifting)
            busy_q <= busy_q - 3'h1;
    end
    // Pulse one character, then scramble idle data
    task send(input logic [7:0] d, input logic fe, input logic pe);
        @(posedge clk);
        rx_in <= {1'b1, d, fe, pe};
        @(posedge clk);
        rx_in <= {1'b0, ~d, 1'b0, 1'b0};
    endtask
endmodule
`default_nettype wire

//--- debug_uart_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_uart_params.svh"
module debug_uart_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, tx_shift_ready, tx_shifting, tx_shift_bit, tx_load;
    logic rx_shift_bit, serial_in_pin, serial_out_pin, rx_enable, tx_enable;
    logic baud_tick, rx_dma_request, tx_dma_request, irq;
    logic [7:0] char_to_send;
    logic [2:0] parity_mode;
    dbg_uart_pkg::rx_event_s rx_in;
    dbg_uart_pkg::dma_status_s dma_in = '0;
    logic rd_pend = 1'b0;
    logic wr_pend = 1'b0;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int pos[6] = '{3, 4, 11, 12, 31, 30};
    logic [7:0] regs[7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};

    always #4 clk = ~clk;

    debug_uart_regs debug_uart_regs_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
        .tx_shift_ready(tx_shift_ready), .tx_shifting(tx_shifting),
        .tx_shift_bit(tx_shift_bit), .tx_load(tx_load), .char_to_send(char_to_send),
        .rx_shift_bit(rx_shift_bit), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .dma_in(dma_in),
        .debug_channel_read_pending(rd_pend), .debug_channel_write_pending(wr_pend),
        .rx_enable(rx_enable), .tx_enable(tx_enable), .parity_mode(parity_mode),
        .baud_tick(baud_tick), .rx_dma_request(rx_dma_request),
        .tx_dma_request(tx_dma_request), .irq(irq));

    host_link_model host_link_model_inst (.clk(clk), .rst_n(rst_n), .tx_load(tx_load),
        .char_to_send(char_to_send), .rx_in(rx_in), .tx_shift_ready(tx_shift_ready),
        .tx_shifting(tx_shifting), .tx_shift_bit(tx_shift_bit),
        .serial_in_pin(serial_in_pin));

    task complete_run;
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task cmp(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        cmp(q & m, x & m);
        cmp({31'h0, e}, {31'h0, ee});
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        int ticks;
        int m;
        logic p;
        logic [31:0] w;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) chk(regs[i], 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        chk(8'h24, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        wr(`OFF_IRQ_SET, 32'hFFFF_FFFF);
        chk(`OFF_IRQ_VIEW, 32'hC000_1AFB, 32'hFFFF_FFFF, 1'b0);
        wr(`OFF_IRQ_CLR, 32'h8000_0001);
        wr(`OFF_IRQ_SET, 32'h0000_0000);
        chk(`OFF_IRQ_VIEW, 32'h4000_1AFA, 32'hFFFF_FFFF, 1'b0);
        wr(`OFF_IRQ_SET, 32'h8000_0001);
        wr(`OFF_IRQ_CLR, 32'h0000_0000);
        chk(`OFF_IRQ_VIEW, 32'hC000_1AFB, 32'hFFFF_FFFF, 1'b0);
        // Each mirrored source alone, with every defined mask bit set
        for (int i = 0; i < 6; i++)
        begin
            w = 32'h1 << i;
            dma_in <= {w[0], w[1], w[2], w[3]};
            rd_pend <= w[4];
            wr_pend <= w[5];
            chk(`OFF_STATUS, 32'h1 << pos[i], 32'hFFFF_FFFF, 1'b0);
            cmp({31'h0, irq}, 32'h1);
        end
        wr(`OFF_IRQ_CLR, 32'hFFFF_FFFF);
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        dma_in <= '0;
        rd_pend <= 1'b0;
        wr_pend <= 1'b0;
        wr(`OFF_CTRL, 32'h0000_0010);
        host_link_model_inst.send(8'hA5, 1'b0, 1'b0);
        chk(`OFF_STATUS, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
        cmp({31'h0, rx_enable}, 32'h1);
        cmp({31'h0, rx_dma_request}, 32'h1);
        chk(`OFF_RX_HOLD, 32'h0000_00A5, 32'hFFFF_FFFF, 1'b0);
        chk(`OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        host_link_model_inst.send(8'h11, 1'b0, 1'b0);
        host_link_model_inst.send(8'h22, 1'b0, 1'b0);
        chk(`OFF_STATUS, 32'h0000_0021, 32'hFFFF_FFFF, 1'b0);
        chk(`OFF_RX_HOLD, 32'h0000_0022, 32'hFFFF_FFFF, 1'b0);
        host_link_model_inst.send(8'h33, 1'b1, 1'b0);
        host_link_model_inst.send(8'h44, 1'b0, 1'b1);
        chk(`OFF_STATUS, 32'h0000_00E0, 32'h0000_00E0, 1'b0);
        chk(`OFF_STATUS, 32'h0000_00E0, 32'h0000_00E0, 1'b0);
        wr(`OFF_CTRL, 32'h0000_0100);
        chk(`OFF_STATUS, 32'h0000_0000, 32'h0000_00E0, 1'b0);
        wr(`OFF_CTRL, 32'h0000_0020);
        chk(`OFF_STATUS, 32'h0000_0000, 32'h0000_0001, 1'b0);
        cmp({31'h0, rx_enable}, 32'h0);
        host_link_model_inst.send(8'h55, 1'b0, 1'b0);
        chk(`OFF_STATUS, 32'h0000_0000, 32'h0000_0001, 1'b0);
        host_link_model_inst.stall_q <= 1'b1;
        wr(`OFF_CTRL, 32'h0000_0040);
        chk(`OFF_STATUS, 32'h0000_0202, 32'h0000_0202, 1'b0);
        cmp({31'h0, tx_enable}, 32'h1);
        cmp({31'h0, tx_dma_request}, 32'h1);
        wr(`OFF_TX_HOLD, 32'h0000_013C);
        chk(`OFF_STATUS, 32'h0000_0000, 32'h0000_0202, 1'b0);
        host_link_model_inst.stall_q <= 1'b0;
        while (host_link_model_inst.nsent != 1 || tx_shifting !== 1'b0)
            @(posedge clk);
        cmp({24'h0, host_link_model_inst.sent_q}, 32'h0000_003C);
        chk(`OFF_STATUS, 32'h0000_0202, 32'h0000_0202, 1'b0);
        wr(`OFF_CTRL, 32'h0000_0080);
        chk(`OFF_STATUS, 32'h0000_0000, 32'h0000_0202, 1'b0);
        cmp({31'h0, tx_enable}, 32'h0);
        // Reset commands drop a pending character
        host_link_model_inst.stall_q <= 1'b1;
        wr(`OFF_CTRL, 32'h0000_0050);
        wr(`OFF_TX_HOLD, 32'h0000_0077);
        wr(`OFF_CTRL, 32'h0000_000C);
        host_link_model_inst.stall_q <= 1'b0;
        repeat (8) @(posedge clk);
        cmp({30'h0, rx_enable, tx_enable}, 32'h0);
        cmp(host_link_model_inst.nsent, 32'h1);
        // Divisor off, pass-through and divide by 16 x 3
        for (int i = 0; i < 3; i++)
        begin
            w = (i == 0) ? 32'h0 : ((i == 1) ? 32'h1 : 32'h3);
            wr(`OFF_BAUD, w | 32'hABCD_0000);
            chk(`OFF_BAUD, w, 32'hFFFF_FFFF, 1'b0);
            ticks = 0;
            repeat (4) @(posedge clk);
            repeat (96)
            begin
                @(posedge clk);
                ticks += (baud_tick === 1'b1) ? 1 : 0;
            end
            cmp(ticks, (i == 0) ? 0 : ((i == 1) ? 96 : 2));
        end
        // Pin routing for each channel mode and both line levels
        for (m = 0; m < 8; m++)
        begin
            p = m[0];
            host_link_model_inst.line_q <= p;
            host_link_model_inst.bit_q <= ~p;
            w = {16'h0, m[2:1], 14'h0} | 32'h0000_0A00;
            wr(`OFF_MODE, w | 32'h0001_0001);
            chk(`OFF_MODE, w, 32'hFFFF_FFFF, 1'b0);
            cmp({29'h0, parity_mode}, 32'h5);
            cmp({31'h0, serial_out_pin},
                (m < 2) ? !p : ((m < 6 && m > 3) ? 1 : p));
            cmp({31'h0, rx_shift_bit},
                (m < 4) ? p : ((m < 6) ? !p : 1));
        end
        complete_run();
    end
endmodule
`default_nettype wire
